// File: hdl/anp_pkg.sv
// Purpose: constants and types for the next-page register pair
// Assumes: 16-bit management registers, 5-bit register address
// Notes: received page image and page strobe come from negotiation logic
//
// Functional notes
// - Outgoing bit 15 is read/write, resets to zero, and says whether more next pages follow.
// - Outgoing bit 13 is read/write, resets to one, and selects message-page or user format.
// - Outgoing bit 12 is a read/write comply acknowledge flag resetting to zero.
// - Outgoing bit 11 is a read/write toggle resetting to zero, set by software to invert the last one.
// - Outgoing bits 10:0 are a read/write code field that resets to one.
// - Outgoing bit 14 is reserved and always reads zero.
// - Received bit 15 is read-only, resets to zero, and shows partner more-pages.
// - Received bit 14 resets to zero and shows the partner acknowledge.
// - Received bit 13 is read-only, resets to zero, and shows the partner page format.
// - Received bit 12 is read-only, resets to zero, and shows partner compliance.
// - Received bit 11 is read-only toggle resetting to zero.
// - Received bits 10:0 are read-only code bits resetting to zero.
// - A new next page loads the received image and sets a latching page-received bit cleared on read.
package anp_pkg;
  // ==========================================================
  // Addresses
  localparam logic [4:0] ADDR_NP_TX = 5'h07;
  localparam logic [4:0] ADDR_NP_RX = 5'h08;

  // ==========================================================
  // Field positions
  localparam int BIT_MORE = 15;
  localparam int BIT_ACK = 14;
  localparam int BIT_MSG = 13;
  localparam int BIT_COMPLY = 12;
  localparam int BIT_TOGGLE = 11;
  localparam int CODE_W = 11;

  // ==========================================================
  // Reset values
  localparam logic [15:0] TX_RESET = 16'h2001;
  localparam logic [15:0] RX_RESET = 16'h0000;
  localparam logic [15:0] TX_WMASK = 16'hbfff;

  // Link code word layout
  typedef struct packed {
    logic more_pages_flag;
    logic ack;
    logic message_page_flag;
    logic comply_ack_flag;
    logic toggle;
    logic [CODE_W-1:0] code;
  } anp_word_t;
endpackage : anp_pkg

// File: hdl/anp_next_page_regs.sv
// Purpose: outgoing and received next-page registers of the management space
// Assumes: single management clock, synchronous reset, one-cycle strobes
// Notes: read data registered one cycle after the read strobe
module anp_next_page_regs
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [4:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic PAGE_RX_STB,
  input wire anp_pkg::anp_word_t PAGE_RX_WORD,
  output anp_pkg::anp_word_t NP_TX_WORD,
  output logic PAGE_RECEIVED
);

  // ==========================================================
  // Internal state
  anp_pkg::anp_word_t tx_word;
  anp_pkg::anp_word_t rx_word;
  anp_pkg::anp_word_t wdata_fields;
  logic tx_more;
  logic tx_msg;
  logic tx_comply;
  logic tx_toggle;
  logic [anp_pkg::CODE_W-1:0] tx_code;
  logic page_rx;
  logic rd_rx;
  logic rd_tx;
  logic wr_tx;
  logic [15:0] next_rdata;

  // Strobe decode; a write elsewhere in the space touches nothing here
  assign wr_tx = REG_WR && (REG_ADDR == anp_pkg::ADDR_NP_TX);
  assign rd_tx = REG_RD && (REG_ADDR == anp_pkg::ADDR_NP_TX);
  assign rd_rx = REG_RD && (REG_ADDR == anp_pkg::ADDR_NP_RX);

  // Write data viewed as a link code word
  assign wdata_fields = REG_WDATA;

  // Outgoing word assembled from its fields; bit 14 has no storage at all
  always_comb
  begin
    tx_word = '0;
    tx_word.more_pages_flag = tx_more;
    tx_word.ack = 1'b0;
    tx_word.message_page_flag = tx_msg;
    tx_word.comply_ack_flag = tx_comply;
    tx_word.toggle = tx_toggle;
    tx_word.code = tx_code;
  end

  // ==========================================================
  // Outgoing more-pages flag
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      tx_more <= anp_pkg::TX_RESET[anp_pkg::BIT_MORE];
    else if (wr_tx)
      tx_more <= wdata_fields.more_pages_flag;
  end

  // Outgoing message-page flag, set after reset
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      tx_msg <= anp_pkg::TX_RESET[anp_pkg::BIT_MSG];
    else if (wr_tx)
      tx_msg <= wdata_fields.message_page_flag;
  end

  // Outgoing comply acknowledge
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      tx_comply <= anp_pkg::TX_RESET[anp_pkg::BIT_COMPLY];
    else if (wr_tx)
      tx_comply <= wdata_fields.comply_ack_flag;
  end

  // Outgoing toggle; software flips it, no automatic inversion here
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      tx_toggle <= anp_pkg::TX_RESET[anp_pkg::BIT_TOGGLE];
    else if (wr_tx)
      tx_toggle <= wdata_fields.toggle;
  end

  // Outgoing code field
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      tx_code <= anp_pkg::TX_RESET[anp_pkg::CODE_W-1:0];
    else if (wr_tx)
      tx_code <= wdata_fields.code;
  end

  // ==========================================================
  // Received image, loaded only by the negotiation side
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      rx_word <= anp_pkg::RX_RESET;
    else if (PAGE_RX_STB)
      rx_word <= PAGE_RX_WORD;
  end

  // Latching flag; new page wins over clear-on-read
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      page_rx <= 1'b0;
    else if (PAGE_RX_STB)
      page_rx <= 1'b1;
    else if (rd_rx)
      page_rx <= 1'b0;
  end

  // ==========================================================
  // Read mux; unmapped addresses return zero so a stray read is harmless
  always_comb
  begin
    next_rdata = '0;
    if (rd_tx)
      next_rdata = tx_word;
    else if (rd_rx)
      next_rdata = rx_word;
  end

  // Read port, one cycle of latency; writes to the received word are ignored
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      REG_RDATA <= '0;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      REG_RDATA <= next_rdata;
    end
  end

  // Registered copies to the negotiation logic
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      NP_TX_WORD <= anp_pkg::TX_RESET;
      PAGE_RECEIVED <= 1'b0;
    end
    else
    begin
      NP_TX_WORD <= tx_word;
      PAGE_RECEIVED <= page_rx;
    end
  end

  // ==========================================================
  // Checks
  // Reset loads the outgoing default word
  chk_tx_reset_val: assert property (
    @(posedge REF_CLK) RST |=> tx_word == anp_pkg::TX_RESET)
    else $error("tx reset value wrong");

  // Reserved bit never reads one
  chk_tx_reserved_zero: assert property (
    @(posedge REF_CLK) disable iff (RST) !tx_word[anp_pkg::BIT_ACK])
    else $error("reserved bit set");

  // A write stores every writable bit
  chk_tx_write_stored: assert property (
    @(posedge REF_CLK) disable iff (RST) wr_tx |=> tx_word == ($past(REG_WDATA) & anp_pkg::TX_WMASK))
    else $error("tx write lost");

  // New page lands whole in the received image
  chk_rx_load_word: assert property (
    @(posedge REF_CLK) disable iff (RST) PAGE_RX_STB |=> rx_word == $past(PAGE_RX_WORD))
    else $error("rx not loaded");

  // Received image moves only on a page strobe
  chk_rx_hold_val: assert property (
    @(posedge REF_CLK) disable iff (RST) !PAGE_RX_STB |=> $stable(rx_word))
    else $error("rx changed");

  // Page strobe shows on the flag output two edges later, read or not
  chk_flag_set_wins: assert property (
    @(posedge REF_CLK) disable iff (RST) PAGE_RX_STB |=> ##1 PAGE_RECEIVED)
    else $error("flag not set");

  // Read of the received word clears the flag
  chk_flag_rd_clear: assert property (
    @(posedge REF_CLK) disable iff (RST) rd_rx && !PAGE_RX_STB |=> !page_rx)
    else $error("flag not cleared");

  // Read of the received word returns the image
  chk_rx_read_data: assert property (
    @(posedge REF_CLK) disable iff (RST) rd_rx |=> REG_RVALID && REG_RDATA == $past(rx_word))
    else $error("rx read bad");

  // Reset clears the received image
  chk_rx_reset_val: assert property (
    @(posedge REF_CLK) RST |=> rx_word == anp_pkg::RX_RESET)
    else $error("rx reset value wrong");

  // Reset clears the latching flag
  chk_flag_reset: assert property (
    @(posedge REF_CLK) RST |=> !page_rx)
    else $error("flag not reset");

  // Read of the outgoing word returns the register
  chk_tx_read_data: assert property (
    @(posedge REF_CLK) disable iff (RST) rd_tx |=> REG_RVALID && REG_RDATA == $past(tx_word))
    else $error("tx read bad");

  // Every read is answered one edge later
  chk_rvalid_follow: assert property (
    @(posedge REF_CLK) disable iff (RST) REG_RD |=> REG_RVALID)
    else $error("read not answered");

  // No answer without a read
  chk_rvalid_pulse: assert property (
    @(posedge REF_CLK) disable iff (RST) !REG_RD |=> !REG_RVALID)
    else $error("spurious read valid");

  // Read data rests at zero between reads
  chk_rdata_idle: assert property (
    @(posedge REF_CLK) disable iff (RST) !REG_RD |=> REG_RDATA == '0)
    else $error("read data not idle");

  // Outgoing word moves only on its own write
  chk_tx_hold_val: assert property (
    @(posedge REF_CLK) disable iff (RST) !wr_tx |=> $stable(tx_word))
    else $error("tx changed");

  // More-pages flag follows its write bit
  chk_tx_more_write: assert property (
    @(posedge REF_CLK) disable iff (RST) wr_tx |=> tx_more == $past(wdata_fields.more_pages_flag))
    else $error("more flag lost");

  // Message-page flag follows its write bit
  chk_tx_msg_write: assert property (
    @(posedge REF_CLK) disable iff (RST) wr_tx |=> tx_msg == $past(wdata_fields.message_page_flag))
    else $error("message flag lost");

  // Comply flag follows its write bit
  chk_tx_comply_write: assert property (
    @(posedge REF_CLK) disable iff (RST) wr_tx |=> tx_comply == $past(wdata_fields.comply_ack_flag))
    else $error("comply flag lost");

  // Toggle follows its write bit
  chk_tx_toggle_write: assert property (
    @(posedge REF_CLK) disable iff (RST) wr_tx |=> tx_toggle == $past(wdata_fields.toggle))
    else $error("toggle lost");

  // Code field follows its write bits
  chk_tx_code_write: assert property (
    @(posedge REF_CLK) disable iff (RST) wr_tx |=> tx_code == $past(wdata_fields.code))
    else $error("code field lost");

  // Writes to the received word are dropped
  chk_rx_write_ignored: assert property (
    @(posedge REF_CLK) disable iff (RST)
    REG_WR && REG_ADDR == anp_pkg::ADDR_NP_RX && !PAGE_RX_STB |=> $stable(rx_word))
    else $error("rx written by software");

  // Partner acknowledge bit loads with the page
  chk_rx_ack_load: assert property (
    @(posedge REF_CLK) disable iff (RST) PAGE_RX_STB |=> rx_word.ack == $past(PAGE_RX_WORD.ack))
    else $error("rx ack not loaded");

  // Partner format bit loads with the page
  chk_rx_msg_load: assert property (
    @(posedge REF_CLK) disable iff (RST)
    PAGE_RX_STB |=> rx_word.message_page_flag == $past(PAGE_RX_WORD.message_page_flag))
    else $error("rx format not loaded");

  // Partner comply bit loads with the page
  chk_rx_comply_load: assert property (
    @(posedge REF_CLK) disable iff (RST)
    PAGE_RX_STB |=> rx_word.comply_ack_flag == $past(PAGE_RX_WORD.comply_ack_flag))
    else $error("rx comply not loaded");

  // Partner toggle loads with the page
  chk_rx_toggle_load: assert property (
    @(posedge REF_CLK) disable iff (RST) PAGE_RX_STB |=> rx_word.toggle == $past(PAGE_RX_WORD.toggle))
    else $error("rx toggle not loaded");

  // Flag latches until a read clears it
  chk_flag_held: assert property (
    @(posedge REF_CLK) disable iff (RST) page_rx && !rd_rx |=> page_rx)
    else $error("flag dropped");

  // Flag output is the latch one edge later
  chk_flag_out_copy: assert property (
    @(posedge REF_CLK) disable iff (RST) 1'b1 |=> PAGE_RECEIVED == $past(page_rx))
    else $error("flag output stale");

  // Negotiation copy trails the register by one edge
  chk_np_copy: assert property (
    @(posedge REF_CLK) disable iff (RST) 1'b1 |=> NP_TX_WORD == $past(tx_word))
    else $error("tx copy stale");

  // Main scenarios
  cov_tx_write: cover property (@(posedge REF_CLK) wr_tx);
  cov_page_then_read: cover property (@(posedge REF_CLK) PAGE_RX_STB ##[1:4] rd_rx);
  cov_set_and_clear: cover property (@(posedge REF_CLK) PAGE_RX_STB && rd_rx);
  cov_rx_write_dropped: cover property (@(posedge REF_CLK) REG_WR && REG_ADDR == anp_pkg::ADDR_NP_RX);

endmodule : anp_next_page_regs

// File: verif/anp_partner_model.sv
// Purpose: negotiation side that hands in received next pages
// Assumes: one page per send pulse
// Notes: word is scrambled while no strobe is shown
module anp_partner_model
(
  input wire logic clk,
  input wire logic send,
  input wire anp_pkg::anp_word_t word,
  output logic stb = 1'b0,
  output anp_pkg::anp_word_t page = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Strobe lasts one cycle; idle word inverted so stale data is caught
  always @(posedge clk)
  begin
    stb <= #1 send;
    page <= #1 send ? word : ~word;
  end
endmodule : anp_partner_model

// File: verif/tb_top.sv
// Purpose: self-checking bench for the next-page registers
// Assumes: 25 MHz clock, sync reset
// Notes: inputs move 1 ns after the rising edge
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, send = 0, stb, got, rv;
  logic [4:0] addr = 5'h00;
  logic [15:0] wd = 16'h0000, rdata, q;
  anp_pkg::anp_word_t pw, txw, sw = 16'h0000;
  int error_cnt = 0, checks_done = 0;
  // ==========
  // Clock and instances
  always #20 clk = ~clk;
  anp_next_page_regs dut (.REF_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_RD(rd), .REG_WDATA(wd), .REG_RDATA(rdata), .REG_RVALID(rv),
    .PAGE_RX_STB(stb), .PAGE_RX_WORD(pw), .NP_TX_WORD(txw), .PAGE_RECEIVED(got));
  anp_partner_model pm (.clk(clk), .send(send), .word(sw), .stb(stb), .page(pw));
  // ==========
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One access; a read waits a bounded time for its valid pulse
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    addr = a;
    wd = d;
    wr = w;
    rd = !w;
    @(posedge clk) #1;
    wr = 0;
    rd = 0;
    for (int i = 0; i < 3 && !w && rv !== 1'b1; i++) @(posedge clk) #1;
    q = rdata;
  endtask : bus
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // ==========
  // Scenarios
  task automatic t_reset;
    bus(0, 5'h07, 16'h0000);
    check({15'h0000, rv}, 16'h0001);
    check(q, 16'h2001);
    check(txw, 16'h2001);
    bus(0, 5'h08, 16'h0000);
    check(q, 16'h0000);
  endtask : t_reset
  // Full word first, then toggle and reserved bit alone; reserved bit and address 8 refuse writes
  task automatic t_write;
    bus(1, 5'h07, 16'hffff);
    bus(0, 5'h07, 16'h0000);
    check(q, 16'hbfff);
    check(txw, 16'hbfff);
    bus(1, 5'h07, 16'h4800);
    bus(0, 5'h07, 16'h0000);
    check(q, 16'h0800);
    bus(1, 5'h08, 16'hffff);
    bus(0, 5'h08, 16'h0000);
    check(q, 16'h0000);
  endtask : t_write
  // Two pages with opposite bits; flag set by page and cleared by read
  task automatic t_page(input logic [15:0] w);
    sw = w;
    send = 1;
    repeat (4) @(posedge clk) #1 send = 0;
    check({15'h0000, got}, 16'h0001);
    bus(0, 5'h08, 16'h0000);
    check(q, w);
    repeat (2) @(posedge clk) #1;
    check({15'h0000, got}, 16'h0000);
  endtask : t_page
  // Page and clearing read on one edge: old word returned, flag stays set
  task automatic t_set_wins(input logic [15:0] old_w, input logic [15:0] w);
    sw = w;
    send = 1;
    @(posedge clk) #1;
    send = 0;
    addr = anp_pkg::ADDR_NP_RX;
    rd = 1;
    @(posedge clk) #1;
    rd = 0;
    check({15'h0000, rv}, 16'h0001);
    check(rdata, old_w);
    @(posedge clk) #1;
    check({15'h0000, got}, 16'h0001);
    bus(0, 5'h08, 16'h0000);
    check(q, w);
    repeat (2) @(posedge clk) #1;
    check({15'h0000, got}, 16'h0000);
  endtask : t_set_wins
  // Reset in mid-run puts both words and the flag back
  task automatic t_mid_reset;
    bus(1, 5'h07, 16'h9234);
    sw = 16'h7fff;
    send = 1;
    repeat (4) @(posedge clk) #1 send = 0;
    check(txw, 16'h9234);
    check({15'h0000, got}, 16'h0001);
    rst = 1;
    repeat (2) @(posedge clk) #1;
    rst = 0;
    check(txw, 16'h2001);
    check({15'h0000, got}, 16'h0000);
    bus(0, 5'h07, 16'h0000);
    check(q, 16'h2001);
    bus(0, 5'h08, 16'h0000);
    check(q, 16'h0000);
  endtask : t_mid_reset
  initial
  begin
    repeat (6) @(posedge clk) #1;
    rst = 0;
    t_reset;
    t_write;
    t_page(16'hf5a5);
    t_page(16'h0a5a);
    t_set_wins(16'h0a5a, 16'h5aa5);
    t_mid_reset;
    tally_and_finish;
  end
  // Whole run is about 60 cycles; the limit sits at 1000 cycles
  initial
  begin
    #40000;
    error_cnt++;
    tally_and_finish;
  end
endmodule : tb_top
